// *** core/tsc_top.sv ***
// seek/tune control registers and engine behind a classic wishbone slave
//
// Behaviour
// - limit bit 10: zero wraps at band edge, one stops there.
// - direction bit 9: zero down, one up.
// - seek bit 8 starts a search from the tuned channel.
// - search ends on qualified channel, whole band covered, or edge in stop mode.
// - completion raises complete flag; fail flag too if nothing qualified.
// - host clears seek bit; both flags drop; nothing starts while high.
// - zero written to seek bit aborts a search.
// - power bit 6 disables, bit 0 enables power-up; both default 0.
// - tune bit 15 starts a tune; complete flag rises at its end.
// - host clears tune bit to drop complete flag before new work.
// - band 00: frequency is spacing times channel plus 87.5 MHz.
// - band 01 or 10: spacing times channel plus 76 MHz.
// - written channel kept during seek; read-back channel tracks tuning.
// - data irq enable, aux two mode 01: 5 ms low pulse on data ready.
// - complete irq enable, aux two mode 01: 5 ms low pulse on completion.
// - bit 12 enables data-service processing, default off.
// - bit 11 de-emphasis: zero 75 us, one 50 us.
// - bit 10 set disables automatic gain control.
// - blend field windows 31-49, 37-55, 19-37, 25-43 dBuV.
// - stereo indicator set while strength exceeds window low end.
// - aux three mode: hi-z, stereo indicator, low, high.
// - aux two mode 01 idles high, low only for interrupt pulses.
// - spacing: 00 200 kHz, 01 100 kHz, 10 50 kHz.
// - band: 00 87.5-108, 01 76-108, 10 76-90 MHz.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module tsc_top #(
    parameter int unsigned PULSE_CYCLES = tsc_pkg::PULSE_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [7:0]  rssi_i,
    input  wire logic        channel_valid_i,
    input  wire logic        data_ready_i,
    output var  logic        aux_pin_two_o,
    output var  logic        aux_pin_two_oe_o,
    output var  logic        aux_pin_three_o,
    output var  logic        aux_pin_three_oe_o,
    output var  logic [9:0]  synth_channel_o,
    output var  logic [18:0] tuned_freq_khz_o,
    output var  logic        busy_o,
    output var  logic        power_up_o,
    output var  logic        data_service_en_o,
    output var  logic        deemphasis_select_o,
    output var  logic        gain_control_off_o
);

    // byte-lane merge of a 16-bit register, reserved bits forced to zero
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  sel,
                                               input logic [15:0] mask);
        logic [15:0] m;
        m = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
        return m & mask;
    endfunction : lane_merge

    // highest channel number of a band at a given spacing
    function automatic logic [9:0] band_top(input logic [1:0] band, input logic [1:0] space);
        logic [9:0] top50;
        top50 = (band == tsc_pkg::BAND_WIDE) ? tsc_pkg::MAXCH_WIDE_50 :
                (band == tsc_pkg::BAND_JAPAN) ? tsc_pkg::MAXCH_JP_50 : tsc_pkg::MAXCH_STD_50;
        case (space)
            2'h0:    return top50 >> 2;
            2'h1:    return top50 >> 1;
            default: return top50;
        endcase
    endfunction : band_top

    // register file
    logic [15:0] power_r;
    logic [15:0] power_nxt;
    logic [15:0] chan_r;
    logic [15:0] chan_nxt;
    logic [15:0] cfg1_r;
    logic [15:0] cfg1_nxt;
    logic [15:0] cfg2_r;
    logic [15:0] cfg2_nxt;

    // engine state
    tsc_pkg::tsc_state_t state_r;
    tsc_pkg::tsc_state_t state_nxt;
    logic [11:0] timer_r;
    logic [11:0] timer_nxt;
    logic [9:0]  rdch_r;
    logic [9:0]  rdch_nxt;
    logic [10:0] steps_r;
    logic [10:0] steps_nxt;
    logic        complete_r;
    logic        complete_nxt;
    logic        fail_r;
    logic        fail_nxt;
    logic        dready_r;
    logic        dready_nxt;
    logic        stereo_r;

    // bus decode
    wire         access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         wr       = access & wb_we_i;
    wire         rd       = access & ~wb_we_i;
    wire  [5:0]  idx      = wb_adr_i[7:2];
    wire  [15:0] wdata    = wb_dat_i[15:0];
    wire  [1:0]  wsel     = wb_sel_i[1:0];

    // field views
    wire         seek_req   = power_r[tsc_pkg::PWR_SEEK_BIT];
    wire         seek_up    = power_r[tsc_pkg::PWR_UP_BIT];
    wire         seek_stop  = power_r[tsc_pkg::PWR_LIMIT_BIT];
    wire         tune_req   = chan_r[tsc_pkg::CH_TUNE_BIT];
    wire  [9:0]  chan_val   = chan_r[tsc_pkg::CH_MSB:0];
    wire  [1:0]  blend_sel  = cfg1_r[tsc_pkg::CFG1_BLEND_LSB +: 2];
    wire  [1:0]  aux3_mode  = cfg1_r[tsc_pkg::CFG1_AUX3_LSB +: 2];
    wire  [1:0]  aux2_mode  = cfg1_r[tsc_pkg::CFG1_AUX2_LSB +: 2];
    wire  [7:0]  seek_thr   = cfg2_r[tsc_pkg::CFG2_THR_LSB +: 8];
    wire  [1:0]  band_sel   = cfg2_r[tsc_pkg::CFG2_BAND_LSB +: 2];
    wire  [1:0]  space_sel  = cfg2_r[tsc_pkg::CFG2_SPACE_LSB +: 2];

    // register writes; reserved positions are masked off
    assign power_nxt = (wr && idx == tsc_pkg::IDX_POWER)
                     ? lane_merge(power_r, wdata, wsel, tsc_pkg::PWR_WMASK) : power_r;
    assign chan_nxt  = (wr && idx == tsc_pkg::IDX_CHANNEL)
                     ? lane_merge(chan_r, wdata, wsel, tsc_pkg::CH_WMASK) : chan_r;
    assign cfg1_nxt  = (wr && idx == tsc_pkg::IDX_SYSCFG1)
                     ? lane_merge(cfg1_r, wdata, wsel, tsc_pkg::CFG1_WMASK) : cfg1_r;
    assign cfg2_nxt  = (wr && idx == tsc_pkg::IDX_SYSCFG2)
                     ? lane_merge(cfg2_r, wdata, wsel, tsc_pkg::CFG2_WMASK) : cfg2_r;

    // band limits and channel stepping
    wire  [9:0]  top_ch     = band_top(band_sel, space_sel);
    wire  [10:0] band_count = {1'b0, top_ch} + 11'h001;
    wire         at_edge    = seek_up ? (rdch_r >= top_ch) : (rdch_r == 10'h000);
    wire  [9:0]  next_ch    = seek_up ? (at_edge ? 10'h000 : rdch_r + 10'h001)
                                      : (at_edge ? top_ch : rdch_r - 10'h001);
    wire         qualified  = channel_valid_i & (rssi_i >= seek_thr);

    // new work only when both flags are low
    wire         flags_low  = ~complete_r & ~fail_r;
    wire         is_idle    = (state_r == tsc_pkg::TSC_IDLE);
    wire         start_tune = is_idle & tune_req & flags_low;
    wire         start_seek = is_idle & ~tune_req & seek_req & flags_low;
    wire         timer_done = (timer_r == 12'h000);
    wire         seek_step  = (state_r == tsc_pkg::TSC_SEEK) & seek_req & timer_done;
    wire         seek_hit   = seek_step & (steps_r != 11'h000) & qualified;
    wire         seek_edge  = seek_step & ~seek_hit & seek_stop & at_edge & (steps_r != 11'h000);
    wire         seek_round = seek_step & ~seek_hit & ~seek_stop & (steps_r == band_count);
    wire         tune_end   = (state_r == tsc_pkg::TSC_TUNE) & timer_done;
    wire         set_fail   = seek_edge | seek_round;
    wire         set_cp     = tune_end | seek_hit | set_fail;
    wire         clr_flags  = ~seek_req & ~tune_req;

    // next state of the seek/tune engine
    always_comb
    begin
        state_nxt = state_r;
        timer_nxt = timer_done ? 12'h000 : timer_r - 12'h001;
        rdch_nxt  = rdch_r;
        steps_nxt = steps_r;
        case (state_r)
            tsc_pkg::TSC_IDLE:
            begin
                if (start_tune)
                begin
                    state_nxt = tsc_pkg::TSC_TUNE;
                    timer_nxt = tsc_pkg::TUNE_LOAD;
                    rdch_nxt  = chan_val;
                end
                else if (start_seek)
                begin
                    state_nxt = tsc_pkg::TSC_SEEK;
                    timer_nxt = tsc_pkg::STEP_LOAD;
                    steps_nxt = 11'h000;
                end
            end
            tsc_pkg::TSC_TUNE:
            begin
                if (timer_done)
                begin
                    state_nxt = tsc_pkg::TSC_IDLE;
                end
            end
            tsc_pkg::TSC_SEEK:
            begin
                if (!seek_req)
                begin
                    state_nxt = tsc_pkg::TSC_IDLE;
                end
                else if (seek_hit || set_fail)
                begin
                    state_nxt = tsc_pkg::TSC_IDLE;
                end
                else if (timer_done)
                begin
                    rdch_nxt  = next_ch;
                    steps_nxt = steps_r + 11'h001;
                    timer_nxt = tsc_pkg::STEP_LOAD;
                end
            end
            default:
            begin
                state_nxt = tsc_pkg::TSC_IDLE;
            end
        endcase
    end

    // flags: a set in the same cycle as a clear wins
    assign complete_nxt = set_cp | (complete_r & ~clr_flags);
    assign fail_nxt     = set_fail | (fail_r & ~clr_flags);

    // data-ready flag, cleared by reading the status register
    wire         dr_set  = data_ready_i & cfg1_r[tsc_pkg::CFG1_DS_EN_BIT];
    wire         dr_clr  = rd && idx == tsc_pkg::IDX_STATUS;
    assign dready_nxt    = dr_set | (dready_r & ~dr_clr);

    // interrupt pulse triggers, only on a flag's rising
    wire         irq_mode = (aux2_mode == tsc_pkg::AUX_FUNC);
    wire         irq_trig = irq_mode &
                            ((cfg1_r[tsc_pkg::CFG1_DS_IRQ_BIT] & dr_set & ~dready_r) |
                             (cfg1_r[tsc_pkg::CFG1_CP_IRQ_BIT] & set_cp & ~complete_r));
    logic        pulse_on;

    tsc_pulse #(
        .CYCLES     (PULSE_CYCLES)
    ) u_pulse (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .trig_i     (irq_trig),
        .active_o   (pulse_on)
    );

    // stereo threshold is the low end of the chosen blend window
    wire  [7:0]  blend_low = (blend_sel == 2'h0) ? tsc_pkg::BLEND_LOW_0 :
                             (blend_sel == 2'h1) ? tsc_pkg::BLEND_LOW_1 :
                             (blend_sel == 2'h2) ? tsc_pkg::BLEND_LOW_2 : tsc_pkg::BLEND_LOW_3;
    wire         stereo_nxt = (rssi_i > blend_low);

    // frequency from band base and spacing
    wire  [7:0]  space_khz = (space_sel == 2'h0) ? tsc_pkg::SPACE_200_KHZ :
                             (space_sel == 2'h1) ? tsc_pkg::SPACE_100_KHZ : tsc_pkg::SPACE_50_KHZ;
    wire  [18:0] base_khz  = (band_sel == tsc_pkg::BAND_WIDE || band_sel == tsc_pkg::BAND_JAPAN)
                           ? tsc_pkg::BASE_WIDE_KHZ : tsc_pkg::BASE_STD_KHZ;
    wire  [17:0] step_khz  = 18'(space_khz * rdch_nxt);
    wire  [18:0] freq_nxt  = base_khz + {1'b0, step_khz};

    // pin drive decode; both aux pins share the same four-mode scheme
    wire         aux2_oe   = (aux2_mode != tsc_pkg::AUX_HIZ);
    wire         aux2_val  = irq_mode ? ~pulse_on : (aux2_mode != tsc_pkg::AUX_LOW);
    wire         aux3_oe   = (aux3_mode != tsc_pkg::AUX_HIZ);
    wire         aux3_val  = (aux3_mode == tsc_pkg::AUX_FUNC) ? stereo_r
                                                              : (aux3_mode != tsc_pkg::AUX_LOW);

    // read data mux, unmapped words read zero
    wire  [15:0] status_v  = {dready_r, complete_r, fail_r, 4'h0, stereo_r, rssi_i};
    wire  [31:0] rdata     = (idx == tsc_pkg::IDX_POWER)    ? {16'h0, power_r} :
                             (idx == tsc_pkg::IDX_CHANNEL)  ? {16'h0, chan_r} :
                             (idx == tsc_pkg::IDX_SYSCFG1)  ? {16'h0, cfg1_r} :
                             (idx == tsc_pkg::IDX_SYSCFG2)  ? {16'h0, cfg2_r} :
                             (idx == tsc_pkg::IDX_STATUS)   ? {16'h0, status_v} :
                             (idx == tsc_pkg::IDX_READCHAN) ? {22'h0, rdch_r} :
                             (idx == tsc_pkg::IDX_FREQ)     ? {13'h0, tuned_freq_khz_o} : 32'h0;

    // registers and bus answer
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            power_r  <= tsc_pkg::REG_RESET;
            chan_r   <= tsc_pkg::REG_RESET;
            cfg1_r   <= tsc_pkg::REG_RESET;
            cfg2_r   <= tsc_pkg::REG_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            power_r  <= power_nxt;
            chan_r   <= chan_nxt;
            cfg1_r   <= cfg1_nxt;
            cfg2_r   <= cfg2_nxt;
            wb_ack_o <= access;
            wb_dat_o <= rd ? rdata : 32'h00000000;
        end
    end

    // engine, flags and status
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_r    <= tsc_pkg::TSC_IDLE;
            timer_r    <= 12'h000;
            rdch_r     <= 10'h000;
            steps_r    <= 11'h000;
            complete_r <= 1'b0;
            fail_r     <= 1'b0;
            dready_r   <= 1'b0;
            stereo_r   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            timer_r    <= timer_nxt;
            rdch_r     <= rdch_nxt;
            steps_r    <= steps_nxt;
            complete_r <= complete_nxt;
            fail_r     <= fail_nxt;
            dready_r   <= dready_nxt;
            stereo_r   <= stereo_nxt;
        end
    end

    // outward pins and controls, all registered; pin lags the pulse timer by one cycle
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            aux_pin_two_o       <= 1'b0;
            aux_pin_two_oe_o    <= 1'b0;
            aux_pin_three_o     <= 1'b0;
            aux_pin_three_oe_o  <= 1'b0;
            synth_channel_o     <= 10'h000;
            tuned_freq_khz_o    <= tsc_pkg::BASE_STD_KHZ;
            busy_o              <= 1'b0;
            power_up_o          <= 1'b0;
            data_service_en_o   <= 1'b0;
            deemphasis_select_o <= 1'b0;
            gain_control_off_o  <= 1'b0;
        end
        else
        begin
            aux_pin_two_o       <= aux2_val;
            aux_pin_two_oe_o    <= aux2_oe;
            aux_pin_three_o     <= aux3_val;
            aux_pin_three_oe_o  <= aux3_oe;
            synth_channel_o     <= rdch_nxt;
            tuned_freq_khz_o    <= freq_nxt;
            busy_o              <= (state_nxt != tsc_pkg::TSC_IDLE);
            power_up_o          <= power_nxt[tsc_pkg::PWR_EN_BIT] & ~power_nxt[tsc_pkg::PWR_DIS_BIT];
            data_service_en_o   <= cfg1_nxt[tsc_pkg::CFG1_DS_EN_BIT];
            deemphasis_select_o <= cfg1_nxt[tsc_pkg::CFG1_DEEMPH_BIT];
            gain_control_off_o  <= cfg1_nxt[tsc_pkg::CFG1_AGC_OFF_BIT];
        end
    end

endmodule : tsc_top

`default_nettype wire

// *** core/tsc_pkg.sv ***
// constants, field layout and state encoding for the tuner seek/tune control block
package tsc_pkg;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_POWER    = 6'h02;
    localparam logic [5:0] IDX_CHANNEL  = 6'h03;
    localparam logic [5:0] IDX_SYSCFG1  = 6'h04;
    localparam logic [5:0] IDX_SYSCFG2  = 6'h05;
    localparam logic [5:0] IDX_STATUS   = 6'h0a;
    localparam logic [5:0] IDX_READCHAN = 6'h0b;
    localparam logic [5:0] IDX_FREQ     = 6'h0c;

    // power_config fields
    localparam int PWR_LIMIT_BIT = 10;
    localparam int PWR_UP_BIT    = 9;
    localparam int PWR_SEEK_BIT  = 8;
    localparam int PWR_DIS_BIT   = 6;
    localparam int PWR_EN_BIT    = 0;

    // channel_select fields
    localparam int CH_TUNE_BIT = 15;
    localparam int CH_MSB      = 9;

    // system_config_one fields
    localparam int CFG1_DS_IRQ_BIT  = 15;
    localparam int CFG1_CP_IRQ_BIT  = 14;
    localparam int CFG1_DS_EN_BIT   = 12;
    localparam int CFG1_DEEMPH_BIT  = 11;
    localparam int CFG1_AGC_OFF_BIT = 10;
    localparam int CFG1_BLEND_LSB   = 6;
    localparam int CFG1_AUX3_LSB    = 4;
    localparam int CFG1_AUX2_LSB    = 2;

    // system_config_two fields
    localparam int CFG2_THR_LSB   = 8;
    localparam int CFG2_BAND_LSB  = 6;
    localparam int CFG2_SPACE_LSB = 4;

    // status fields
    localparam int STAT_DR_BIT     = 15;
    localparam int STAT_CP_BIT     = 14;
    localparam int STAT_FAIL_BIT   = 13;
    localparam int STAT_STEREO_BIT = 8;

    // writable-bit masks, reserved bits stay zero
    localparam logic [15:0] PWR_WMASK  = 16'hef41;
    localparam logic [15:0] CH_WMASK   = 16'h83ff;
    localparam logic [15:0] CFG1_WMASK = 16'hdcff;
    localparam logic [15:0] CFG2_WMASK = 16'hffff;
    localparam logic [15:0] REG_RESET  = 16'h0000;

    // aux pin modes
    localparam logic [1:0] AUX_HIZ  = 2'h0;
    localparam logic [1:0] AUX_FUNC = 2'h1;
    localparam logic [1:0] AUX_LOW  = 2'h2;

    // band, spacing and blend tables
    localparam logic [1:0]  BAND_WIDE     = 2'h1;
    localparam logic [1:0]  BAND_JAPAN    = 2'h2;
    localparam logic [18:0] BASE_STD_KHZ  = 19'h155cc;  // 87500 kHz
    localparam logic [18:0] BASE_WIDE_KHZ = 19'h128e0;  // 76000 kHz
    localparam logic [7:0]  SPACE_200_KHZ = 8'hc8;
    localparam logic [7:0]  SPACE_100_KHZ = 8'h64;
    localparam logic [7:0]  SPACE_50_KHZ  = 8'h32;
    localparam logic [9:0]  MAXCH_STD_50  = 10'h19a;    // 410 steps of 50 kHz
    localparam logic [9:0]  MAXCH_WIDE_50 = 10'h280;    // 640
    localparam logic [9:0]  MAXCH_JP_50   = 10'h118;    // 280
    localparam logic [7:0]  BLEND_LOW_0   = 8'h1f;      // 31
    localparam logic [7:0]  BLEND_LOW_1   = 8'h25;      // 37
    localparam logic [7:0]  BLEND_LOW_2   = 8'h13;      // 19
    localparam logic [7:0]  BLEND_LOW_3   = 8'h19;      // 25

    // timing
    localparam int CLK_MHZ        = 200;
    localparam int TUNE_TIME_US   = 10;
    localparam int STEP_TIME_US   = 5;
    localparam int PULSE_TIME_US  = 5000;
    localparam int TUNE_CYC       = TUNE_TIME_US * CLK_MHZ;
    localparam int STEP_CYC       = STEP_TIME_US * CLK_MHZ;
    localparam int PULSE_CYC      = PULSE_TIME_US * CLK_MHZ;
    localparam logic [11:0] TUNE_LOAD = 12'(TUNE_CYC - 1);
    localparam logic [11:0] STEP_LOAD = 12'(STEP_CYC - 1);

    typedef enum logic [2:0] {
        TSC_IDLE = 3'b001,
        TSC_TUNE = 3'b010,
        TSC_SEEK = 3'b100
    } tsc_state_t;

endpackage : tsc_pkg

// *** core/tsc_pulse.sv ***
// retriggerable fixed-length pulse timer for the interrupt pin
`timescale 1ns/10ps
`default_nettype none

module tsc_pulse #(
    parameter int unsigned CYCLES = 1000000
) (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic trig_i,
    output var  logic active_o
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // a new event restarts the full length rather than being lost
    assign cnt_nxt = trig_i ? W'(CYCLES) : ((cnt_r != '0) ? cnt_r - W'(1) : '0);

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cnt_r    <= '0;
            active_o <= 1'b0;
        end
        else
        begin
            cnt_r    <= cnt_nxt;
            active_o <= (cnt_nxt != '0);
        end
    end
endmodule : tsc_pulse

`default_nettype wire

// *** test/tsc_top_chk.sv ***
// bus, reset and tuning assertions on the seek/tune control ports
`timescale 1ns/10ps
`default_nettype none

module tsc_top_chk (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        aux_pin_two_o,
    input wire logic        aux_pin_two_oe_o,
    input wire logic        aux_pin_three_oe_o,
    input wire logic [9:0]  synth_channel_o,
    input wire logic [18:0] tuned_freq_khz_o,
    input wire logic        busy_o,
    input wire logic        power_up_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // bus answers once, one cycle after the request is taken
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0)
        else $error("upper half set");
    // tuned channel only moves while the engine works
    chk_chan_hold: assert property ($changed(synth_channel_o) |-> busy_o || $past(busy_o))
        else $error("channel moved idle");
    chk_freq_range: assert property (tuned_freq_khz_o >= 19'h128e0 && tuned_freq_khz_o <= 19'h1a5e0)
        else $error("frequency range");
    chk_reset_pins: assert property ($past(reset_i) |-> !aux_pin_two_oe_o && !aux_pin_three_oe_o)
        else $error("pin driven");
    chk_reset_power: assert property ($past(reset_i) |-> !power_up_o && !busy_o)
        else $error("active after reset");

    cov_busy: cover property ($rose(busy_o));
    cov_pulse: cover property (aux_pin_two_oe_o && $fell(aux_pin_two_o));
    cov_write: cover property (wb_ack_o && wb_we_i);
endmodule : tsc_top_chk

bind tsc_top tsc_top_chk u_tsc_top_chk (.*);

`default_nettype wire

// *** test/tsc_host.sv ***
// host controller model: classic wishbone master for the tuner registers
`timescale 1ns/10ps
`default_nettype none

module tsc_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output var  logic        cyc_o,
    output var  logic        stb_o,
    output var  logic        we_o,
    output var  logic [7:0]  adr_o,
    output var  logic [3:0]  sel_o,
    output var  logic [31:0] dat_o
);
    // bus idle from time zero
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end

    // one classic cycle, raised just after an edge; upper half zero
    task automatic xfer(input logic w, input logic [5:0] i, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'h3, w};
        adr_o <= {i, 2'h0};
        sel_o <= 4'h3;
        dat_o <= {16'h0, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i[15:0];
        {cyc_o, stb_o} <= 2'h0;
    endtask : xfer
endmodule : tsc_host

`default_nettype wire

// *** test/test_tsc_top.sv ***
// register-level testbench for the seek/tune control block
`timescale 1ns/10ps
`default_nettype none

module test_tsc_top;
    logic        core_clk_i = 1'b0, reset_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o, power_up_o;
    logic [7:0]  wb_adr_i, rssi_i = 8'h00;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        channel_valid_i = 1'b0, data_ready_i = 1'b0, aux_pin_two_o, aux_pin_two_oe_o;
    logic        aux_pin_three_o, aux_pin_three_oe_o, data_service_en_o, deemphasis_select_o, gain_control_off_o;
    logic [9:0]  synth_channel_o;
    logic [18:0] tuned_freq_khz_o;
    logic [15:0] q;
    logic [7:0]  lows [4] = '{8'h1f, 8'h25, 8'h13, 8'h19};
    int          n_mismatch = 0;
    int          num_checks = 0;
    localparam logic [5:0] pw = tsc_pkg::IDX_POWER, ch = tsc_pkg::IDX_CHANNEL, c1 = tsc_pkg::IDX_SYSCFG1;
    localparam logic [5:0] c2 = tsc_pkg::IDX_SYSCFG2, st = tsc_pkg::IDX_STATUS, rb = tsc_pkg::IDX_READCHAN;

    tsc_top #(.PULSE_CYCLES(20)) u_tsc_top (.*);
    tsc_host u_tsc_host (.clk_i(core_clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

    // 200 MHz clock
    initial
    begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // edges, then settle
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        u_tsc_host.xfer(1'b1, i, d, q);
        tick(0);
    endtask : wr
    task automatic rdc(input string nm, input logic [5:0] i, input logic [15:0] m, input logic [15:0] e);
        u_tsc_host.xfer(1'b0, i, 16'h0, q);
        tick(0);
        chk(nm, {3'h0, e}, {3'h0, q & m});
    endtask : rdc
    // bounded by timeout
    task automatic wait_idle();
        while (busy_o !== 1'b0) tick(1);
    endtask : wait_idle
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // hang guard: run needs about 12000 cycles
    initial
    begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        tick(1);
        rdc("power", pw, 16'hffff, 16'h0);
        rdc("cfg1", c1, 16'hffff, 16'h0);
        rdc("unmapped", 6'h3f, 16'hffff, 16'h0);
        chk("freq", 19'h155cc, tuned_freq_khz_o);
        wr(pw, 16'h0041);
        chk("power", 1'b0, power_up_o);
        wr(pw, 16'h0001);
        chk("power", 1'b1, power_up_o);
        wr(c1, 16'h1c00);
        chk("cfg outs", 3'h7, {data_service_en_o, deemphasis_select_o, gain_control_off_o});
        for (int m = 0; m < 4; m++)
        begin
            wr(c1, 16'(m << 4));
            chk("aux3", {m != 0, m == 3}, {aux_pin_three_oe_o, aux_pin_three_o & aux_pin_three_oe_o});
        end
        for (int b = 0; b < 4; b++)
        begin
            wr(c1, 16'((b << 6) | 16'h10));
            @(posedge core_clk_i) rssi_i <= lows[b];
            tick(3);
            chk("stereo", 1'b0, aux_pin_three_o);
            @(posedge core_clk_i) rssi_i <= lows[b] + 8'h01;
            tick(3);
            chk("stereo", 1'b1, aux_pin_three_o);
        end
        // tune, completion pulse and hold-off
        wr(c1, 16'h4004);
        chk("aux2 idle", 1'b1, aux_pin_two_o & aux_pin_two_oe_o);
        wr(ch, 16'h8005);
        chk("busy", 1'b1, busy_o);
        wait_idle();
        rdc("status", st, 16'h6000, 16'h4000);
        chk("freq", 19'h159b4, tuned_freq_khz_o);
        chk("aux2 pulse", 1'b0, aux_pin_two_o);
        tick(25);
        chk("aux2 idle", 1'b1, aux_pin_two_o);
        wr(ch, 16'h8007);
        tick(5);
        chk("held off", 1'b0, busy_o);
        wr(ch, 16'h0007);
        rdc("status", st, 16'h6000, 16'h0);
        wr(c2, 16'h0050);
        wr(ch, 16'h8045);
        wait_idle();
        chk("freq", 19'h143d4, tuned_freq_khz_o);
        wr(ch, 16'h0045);
        // seek up, stop mode, edge at 70
        wr(c2, 16'h0080);
        wr(pw, 16'h0701);
        wait_idle();
        rdc("status", st, 16'h6000, 16'h6000);
        rdc("readback", rb, 16'h03ff, 16'h0046);
        chk("synth", 19'h46, synth_channel_o);
        rdc("channel", ch, 16'hffff, 16'h0045);
        wr(pw, 16'h0001);
        rdc("status", st, 16'h6000, 16'h0);
        // seek down finds the first qualifying channel
        @(posedge core_clk_i) channel_valid_i <= 1'b1;
        wr(pw, 16'h0101);
        wait_idle();
        rdc("status", st, 16'h6000, 16'h4000);
        rdc("readback", rb, 16'h03ff, 16'h0045);
        wr(pw, 16'h0001);
        // wrap mode passes the edge, then abort
        @(posedge core_clk_i) channel_valid_i <= 1'b0;
        wr(pw, 16'h0301);
        tick(3500);
        rdc("readback", rb, 16'h03ff, 16'h0001);
        wr(pw, 16'h0001);
        chk("aborted", 1'b0, busy_o);
        rdc("status", st, 16'h6000, 16'h0);
        // data-ready interrupt pulse
        wr(c1, 16'h9004);
        @(posedge core_clk_i) data_ready_i <= 1'b1;
        @(posedge core_clk_i) data_ready_i <= 1'b0;
        tick(4);
        chk("aux2 pulse", 1'b0, aux_pin_two_o);
        rdc("status", st, 16'h8000, 16'h8000);
        wrap_up();
    end
endmodule : test_tsc_top

`default_nettype wire
